// ==== hdl/pdbh_map.svh ====
// Operation
// - Controller grants device memory via select/ready sequencing
// - Controller serves host read/write on request
// - Host waits until device transfer completes
// - Host transfers limited to 64 data cycles
// - Idle bus keeps address select low
// - Capture address after request, then raise select
// - Select low on end, held until next
// - Non-burst mode holds select high, ready low; code has no such mode, select drops low after each device transfer
// - One tri-state cycle between bus drivers
// - Idle bus parked with device in address mode
// - Parked bus raises select with request
// - Clean-up select/ready choose address or tri-state
`ifndef PDBH_MAP_SVH
`define PDBH_MAP_SVH
// ********************************
// Sizes and limits
// ********************************
`define PDBH_MAX_DATA_CYCLES 7'h40
`define PDBH_HOST_MAX_CYCLES 7'h40
`define PDBH_ADDR_W 32
`define PDBH_HOST_ADDR_W 18
`define PDBH_TURN_CYCLES 2'h1
`define PDBH_ADDR_LSB_IGNORE 2
`endif

// ==== hdl/pdbh_pkg.sv ====
package pdbh_pkg;
    // Arbiter states
    typedef enum logic [2:0] {
        PDBH_PARK, PDBH_DMA_ADDR, PDBH_DMA_DATA, PDBH_DMA_END,
        PDBH_TURN, PDBH_HOST_XFER, PDBH_TURN_BACK
    } pdbh_state_e;
    typedef logic [31:0] pdbh_word_t;
endpackage

// ==== hdl/pdbh_host_if.sv ====
`timescale 1ns/1ps
// Host request carrier to the counter module
interface pdbh_host_if;
    logic load;
    logic [6:0] len;
    logic tick;
    logic done;
    modport ctl (output load, output len, output tick, input done);
    modport cnt (input load, input len, input tick, output done);
endinterface

// ==== hdl/pdbh_beat_cnt.sv ====
`timescale 1ns/1ps
// ********************************
// Data cycle limit counter
// ********************************
module pdbh_beat_cnt
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    pdbh_host_if.cnt hif
);
    logic [6:0] left_ff;
    // Down counter; done when one beat remains
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            left_ff <= 7'h00;
        else if (hif.load)
            left_ff <= hif.len;
        else if (hif.tick && left_ff != 7'h00)
            left_ff <= left_ff - 7'h01;
    end
    assign hif.done = (left_ff <= 7'h01);
endmodule

// ==== hdl/pdbh_ctrl.sv ====
`timescale 1ns/1ps
`include "pdbh_map.svh"
// ********************************
// Wide port bus controller (host side)
// ********************************
module pdbh_ctrl import pdbh_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    // Device handshake
    input wire logic WIDE_QUEUE_REQUEST_N_IN,
    input wire logic WIDE_TRANSFER_REQUEST_N_IN,
    input wire logic WIDE_READ_NOT_WRITE_IN,
    input wire logic WIDE_LAST_CYCLE_N_IN,
    input wire logic [1:0] WIDE_HALFWORD_WRITE_EN_IN,
    input wire logic [31:0] WIDE_ADDR_DATA_BUS_IN,
    output logic WIDE_ADDR_SELECT_N_OUT,
    output logic WIDE_TARGET_READY_N_OUT,
    output logic COMM_REGISTER_SELECT_OUT,
    // Memory side
    output logic MEM_WE_OUT,
    output logic [1:0] MEM_HALF_EN_OUT,
    output logic [31:0] MEM_ADDR_OUT,
    output logic [31:0] MEM_WDATA_OUT,
    output logic MEM_RD_OUT,
    input wire logic MEM_READY_IN,
    // Host bus agent
    input wire logic HOST_REQ_IN,
    input wire logic [6:0] HOST_LEN_IN,
    output logic HOST_GRANT_OUT,
    output logic HOST_DONE_OUT,
    output logic DMA_ACTIVE_OUT
);
    logic rst_s1_ff;
    logic rst_n_ff;
    pdbh_state_e state_ff;
    pdbh_state_e nxt_state;
    logic [31:0] addr_ff;
    logic [6:0] beats_ff;
    logic rnw_ff;
    logic beat;
    pdbh_host_if hif();

    // Reset release through two flops
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            rst_s1_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_n_ff <= rst_s1_ff;
        end
    end

    // Host transfer length limiter
    pdbh_beat_cnt u_cnt
    (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(rst_n_ff),
        .hif(hif)
    );

    // Strip the low two byte bits: reads are whole words
    function automatic pdbh_word_t word_addr(input pdbh_word_t a);
        word_addr = {a[31:`PDBH_ADDR_LSB_IGNORE], 2'b00};
    endfunction

    // Clamp a host length to the allowed cycles
    function automatic logic [6:0] clamp_len(input logic [6:0] l);
        if (l == 7'h00 || l > `PDBH_HOST_MAX_CYCLES)
            clamp_len = `PDBH_HOST_MAX_CYCLES;
        else
            clamp_len = l;
    endfunction

    assign hif.load = (state_ff == PDBH_TURN) && HOST_REQ_IN;
    assign hif.len = clamp_len(HOST_LEN_IN);
    assign hif.tick = (state_ff == PDBH_HOST_XFER) && MEM_READY_IN;

    // Beat taken where the device saw our ready low; both sides count alike
    assign beat = (state_ff == PDBH_DMA_DATA) && !WIDE_TARGET_READY_N_OUT;

    // ********************************
    // Arbiter
    // ********************************
    // Next state; device transfer always finishes before the host
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            PDBH_PARK:
                // Device request wins; one cycle of select high before data
                if (!WIDE_TRANSFER_REQUEST_N_IN)
                    nxt_state = PDBH_DMA_ADDR;
                else if (HOST_REQ_IN && WIDE_QUEUE_REQUEST_N_IN)
                    nxt_state = PDBH_TURN;
            PDBH_DMA_ADDR:
                nxt_state = PDBH_DMA_DATA;
            PDBH_DMA_DATA:
                // Only a taken beat ends it; a wait cycle with end low does not
                if (beat && (!WIDE_LAST_CYCLE_N_IN
                    || beats_ff == `PDBH_MAX_DATA_CYCLES - 7'h01))
                    nxt_state = PDBH_DMA_END;
            PDBH_DMA_END:
                nxt_state = PDBH_PARK;
            PDBH_TURN:
                nxt_state = HOST_REQ_IN ? PDBH_HOST_XFER : PDBH_TURN_BACK;
            PDBH_HOST_XFER:
                if (hif.done && MEM_READY_IN)
                    nxt_state = PDBH_TURN_BACK;
            PDBH_TURN_BACK:
                nxt_state = PDBH_PARK;
            default:
                nxt_state = PDBH_PARK;
        endcase
    end

    // State register, rising edge only
    always_ff @(posedge SYS_CLK_IN or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            state_ff <= PDBH_PARK;
        else
            state_ff <= nxt_state;
    end

    // ********************************
    // Outputs
    // ********************************
    // Handshake outputs: select low and ready low while parked
    always_ff @(posedge SYS_CLK_IN or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            WIDE_ADDR_SELECT_N_OUT <= 1'b0;
            WIDE_TARGET_READY_N_OUT <= 1'b0;
            COMM_REGISTER_SELECT_OUT <= 1'b0;
        end
        else
        begin
            // Parked: device in address mode keeps bus driven
            WIDE_ADDR_SELECT_N_OUT <= (nxt_state == PDBH_DMA_ADDR)
                || (nxt_state == PDBH_DMA_DATA);
            // Ready high in turnaround gives the tri-state cycle
            WIDE_TARGET_READY_N_OUT <= (nxt_state == PDBH_TURN)
                || (nxt_state == PDBH_HOST_XFER) || (nxt_state == PDBH_TURN_BACK)
                || ((nxt_state == PDBH_DMA_DATA) && !MEM_READY_IN);
            COMM_REGISTER_SELECT_OUT <= 1'b0;
        end
    end

    // Capture address when request first seen
    always_ff @(posedge SYS_CLK_IN or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            addr_ff <= 32'h0000_0000;
            rnw_ff <= 1'b1;
        end
        else if (state_ff == PDBH_PARK && !WIDE_TRANSFER_REQUEST_N_IN)
        begin
            addr_ff <= word_addr(WIDE_ADDR_DATA_BUS_IN);
            rnw_ff <= WIDE_READ_NOT_WRITE_IN;
        end
        else if (beat)
            addr_ff <= addr_ff + 32'h0000_0004;
    end

    // Data cycle counter for the device transfer
    always_ff @(posedge SYS_CLK_IN or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            beats_ff <= 7'h00;
        else if (state_ff == PDBH_PARK)
            beats_ff <= 7'h00;
        else if (beat)
            beats_ff <= beats_ff + 7'h01;
    end

    // Memory strobes; write halves follow device enables
    always_ff @(posedge SYS_CLK_IN or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            MEM_WE_OUT <= 1'b0;
            MEM_RD_OUT <= 1'b0;
            MEM_HALF_EN_OUT <= 2'h0;
            MEM_ADDR_OUT <= 32'h0000_0000;
            MEM_WDATA_OUT <= 32'h0000_0000;
        end
        else
        begin
            // One strobe per taken beat; valid data each cycle after select
            MEM_WE_OUT <= beat && !rnw_ff;
            MEM_RD_OUT <= beat && rnw_ff;
            // Word of the last taken beat stands until the next one
            if (beat)
            begin
                MEM_HALF_EN_OUT <= rnw_ff ? 2'h3 : WIDE_HALFWORD_WRITE_EN_IN;
                MEM_ADDR_OUT <= addr_ff;
                MEM_WDATA_OUT <= WIDE_ADDR_DATA_BUS_IN;
            end
        end
    end

    // Host status flags
    always_ff @(posedge SYS_CLK_IN or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            HOST_GRANT_OUT <= 1'b0;
            HOST_DONE_OUT <= 1'b0;
            DMA_ACTIVE_OUT <= 1'b0;
        end
        else
        begin
            HOST_GRANT_OUT <= (nxt_state == PDBH_HOST_XFER);
            HOST_DONE_OUT <= (state_ff == PDBH_HOST_XFER) && (nxt_state == PDBH_TURN_BACK);
            DMA_ACTIVE_OUT <= (nxt_state == PDBH_DMA_ADDR) || (nxt_state == PDBH_DMA_DATA)
                || (nxt_state == PDBH_DMA_END);
        end
    end
endmodule

// ==== verif/pdbh_ctrl_asserts.sv ====
`timescale 1ns/1ps
// ****
// Port handshake checker
// ****
module pdbh_ctrl_chk (
    // Watched ports
    input wire logic SYS_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic WIDE_TRANSFER_REQUEST_N_IN,
    input wire logic WIDE_LAST_CYCLE_N_IN,
    input wire logic WIDE_ADDR_SELECT_N_OUT,
    input wire logic WIDE_TARGET_READY_N_OUT,
    input wire logic COMM_REGISTER_SELECT_OUT,
    input wire logic MEM_WE_OUT,
    input wire logic MEM_RD_OUT,
    input wire logic MEM_READY_IN,
    input wire logic HOST_REQ_IN,
    input wire logic HOST_GRANT_OUT,
    input wire logic HOST_DONE_OUT,
    input wire logic DMA_ACTIVE_OUT
);
    logic [7:0] beats_ff;
    // Beats of one tenure; idle clears so the owners never add up
    always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            beats_ff <= 8'h00;
        else if (!DMA_ACTIVE_OUT && !HOST_GRANT_OUT)
            beats_ff <= 8'h00;
        else if (MEM_WE_OUT || MEM_RD_OUT || (HOST_GRANT_OUT && MEM_READY_IN))
            beats_ff <= beats_ff + 8'h01;
    end
    default clocking @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);
    comm_low_a: assert property (!COMM_REGISTER_SELECT_OUT)
        else $error("comm select high");
    sel_answer_a: assert property (
        $fell(WIDE_TRANSFER_REQUEST_N_IN) && !WIDE_ADDR_SELECT_N_OUT && !WIDE_TARGET_READY_N_OUT
        && !HOST_GRANT_OUT |-> ##[1:2] WIDE_ADDR_SELECT_N_OUT) else $error("select late");
    end_drop_a: assert property (
        WIDE_ADDR_SELECT_N_OUT && !WIDE_LAST_CYCLE_N_IN && !WIDE_TARGET_READY_N_OUT
        |=> !WIDE_ADDR_SELECT_N_OUT) else $error("select kept after end");
    host_excl_a: assert property (DMA_ACTIVE_OUT |-> !HOST_GRANT_OUT)
        else $error("host granted in burst");
    turn_ready_a: assert property (HOST_GRANT_OUT |-> WIDE_TARGET_READY_N_OUT)
        else $error("ready low in host turn");
    beat_limit_a: assert property (beats_ff <= 8'h40)
        else $error("too many beats");
    done_pulse_a: assert property (HOST_DONE_OUT |=> !HOST_DONE_OUT)
        else $error("done not a pulse");
    park_back_a: assert property (
        $fell(DMA_ACTIVE_OUT) && !HOST_REQ_IN
        |-> ##[0:3] (!WIDE_ADDR_SELECT_N_OUT && !WIDE_TARGET_READY_N_OUT)) else $error("no park");
endmodule

// ==== verif/pdbh_dev_model.sv ====
`timescale 1ns/1ps
// ****
// Device side of the wide port
// ****
module pdbh_dev_model (
    // Clock and handshake
    input wire logic clk_in,
    input wire logic sel_n_in,
    input wire logic rdy_n_in,
    input wire logic com_in,
    // Device drive, idle in address mode
    output logic qrq_n_out = 1'b1,
    output logic rq_n_out = 1'b1,
    output logic rd_out = 1'b1,
    output logic end_n_out = 1'b1,
    output logic [1:0] hwe_out = 2'h0,
    output logic [31:0] ad_out = 32'h0
);
    // One burst of n beats, n from 1 to 64
    task automatic burst(input logic [31:0] a, input logic r, input int n, input logic [31:0] b);
        int k;
        k = 0;
        while (sel_n_in || rdy_n_in || com_in)
            @(posedge clk_in);
        qrq_n_out <= 1'b0;
        rq_n_out <= 1'b0;
        rd_out <= r;
        ad_out <= a;
        @(posedge clk_in);
        while (!sel_n_in)
            @(posedge clk_in);
        qrq_n_out <= 1'b1;
        rq_n_out <= 1'b1;
        while (k < n)
        begin
            ad_out <= b + 32'(k);
            hwe_out <= (r || k > 0 || !a[1]) ? 2'h3 : 2'h1;
            end_n_out <= (k != n - 1);
            @(posedge clk_in);
            if (!rdy_n_in)
                k++;
        end
        end_n_out <= 1'b1;
        ad_out <= a;
    endtask
endmodule

// ==== verif/pdbh_ctrl_test.sv ====
`timescale 1ns/1ps
// ****
// Controller bench
// ****
module pdbh_ctrl_test;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic rdy = 1'b1;
    logic h_req = 1'b0;
    logic got = 1'b0;
    logic [6:0] h_len = 7'h01;
    logic qrq_n, rq_n, rd, end_n, sel_n, rdy_n, com, we, re, grant, done, act;
    logic [1:0] hwe, half;
    logic [31:0] ad, m_a, m_d;
    logic [66:0] q[$];
    logic [66:0] e;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    pdbh_dev_model i_pdbh_dev_model (.clk_in(clk), .sel_n_in(sel_n), .rdy_n_in(rdy_n),
        .com_in(com), .qrq_n_out(qrq_n), .rq_n_out(rq_n), .rd_out(rd), .end_n_out(end_n),
        .hwe_out(hwe), .ad_out(ad));
    pdbh_ctrl i_pdbh_ctrl (.SYS_CLK_IN(clk), .ARST_N_IN(arst_n), .WIDE_QUEUE_REQUEST_N_IN(qrq_n),
        .WIDE_TRANSFER_REQUEST_N_IN(rq_n), .WIDE_READ_NOT_WRITE_IN(rd),
        .WIDE_LAST_CYCLE_N_IN(end_n), .WIDE_HALFWORD_WRITE_EN_IN(hwe), .WIDE_ADDR_DATA_BUS_IN(ad),
        .WIDE_ADDR_SELECT_N_OUT(sel_n), .WIDE_TARGET_READY_N_OUT(rdy_n),
        .COMM_REGISTER_SELECT_OUT(com), .MEM_WE_OUT(we), .MEM_HALF_EN_OUT(half),
        .MEM_ADDR_OUT(m_a), .MEM_WDATA_OUT(m_d), .MEM_RD_OUT(re), .MEM_READY_IN(rdy),
        .HOST_REQ_IN(h_req), .HOST_LEN_IN(h_len), .HOST_GRANT_OUT(grant), .HOST_DONE_OUT(done),
        .DMA_ACTIVE_OUT(act));
    task automatic check(input string w, input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", w, x, s);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Model beats: word address, low two bits dropped
    task automatic dma(input logic [31:0] a, input logic r, input int n);
        logic [31:0] b;
        b = $urandom;
        if (!r)
            a[0] = 1'b0;
        for (int k = 0; k < n; k++)
            q.push_back({r, (r || k > 0 || !a[1]) ? 2'h3 : 2'h1, (a & ~32'h3) + 32'(4 * k), b + 32'(k)});
        i_pdbh_dev_model.burst(a, r, n, b);
    endtask
    // Memory stalls at random; every device beat is compared
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            report_and_stop();
        end
        rdy <= ($urandom % 4) != 0;
        if (done)
            got <= 1'b1;
        if ((we || re) && !grant)
        begin
            e = q.size() ? q.pop_front() : {67{1'bx}};
            check("kind", {30'h0, re, we}, {30'h0, e[66], !e[66]});
            check("half", {30'h0, half}, {30'h0, e[65:64]});
            check("addr", m_a, e[63:32]);
            if (!e[66])
                check("wdata", m_d, e[31:0]);
        end
    end
    initial
    begin
        void'($urandom(32'h3968));
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // Single and full-length bursts, then random lengths
        for (int i = 0; i < 8; i++)
            dma($urandom, i[0], i < 2 ? 1 : (i < 4 ? 64 : int'($urandom_range(63, 2))));
        // Host asks in mid-burst and must wait
        h_len <= 7'($urandom_range(127, 0));
        fork
            dma($urandom, 1'b0, 20);
            begin
                repeat (5) @(posedge clk);
                h_req <= 1'b1;
            end
        join
        for (int w = 0; w < 300 && !got; w++)
            @(posedge clk);
        h_req <= 1'b0;
        check("host done", {31'h0, got}, 32'h1);
        dma($urandom, 1'b1, 3);
        repeat (10) @(posedge clk);
        check("left", 32'(q.size()), 32'h0);
        report_and_stop();
    end
endmodule
bind pdbh_ctrl pdbh_ctrl_chk i_chk (.SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN),
    .WIDE_TRANSFER_REQUEST_N_IN(WIDE_TRANSFER_REQUEST_N_IN),
    .WIDE_LAST_CYCLE_N_IN(WIDE_LAST_CYCLE_N_IN), .WIDE_ADDR_SELECT_N_OUT(WIDE_ADDR_SELECT_N_OUT),
    .WIDE_TARGET_READY_N_OUT(WIDE_TARGET_READY_N_OUT),
    .COMM_REGISTER_SELECT_OUT(COMM_REGISTER_SELECT_OUT), .MEM_WE_OUT(MEM_WE_OUT),
    .MEM_RD_OUT(MEM_RD_OUT), .MEM_READY_IN(MEM_READY_IN), .HOST_REQ_IN(HOST_REQ_IN),
    .HOST_GRANT_OUT(HOST_GRANT_OUT), .HOST_DONE_OUT(HOST_DONE_OUT),
    .DMA_ACTIVE_OUT(DMA_ACTIVE_OUT));
